//--- hdl/dimming_mode_and_on_time_regs.sv
`timescale 1ns/1ps
module dimming_mode_and_on_time_regs
  import dim_regs_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h28
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // serial register port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // dimming sources
  input wire logic dim_pin_in,
  input wire logic [17:0] pwm_period_in,
  input wire logic [15:0] ch4_on_time_upper_in,
  // mode outputs
  output logic external_dim_select_out,
  output logic hybrid_dim_enable_out,
  output logic [1:0] crossover_threshold_field_out,
  // on-time values
  output logic [17:0] ch1_on_time_value_out,
  output logic [17:0] ch2_on_time_value_out,
  output logic [17:0] ch3_on_time_value_out,
  output logic [1:0] ch4_on_time_lsbs_out,
  // channel drive and status
  output logic [3:0] ch_pwm_out,
  output logic [3:0] ch_low_level_flag_out
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [3:0] mode_ctrl_reg;
  logic [7:0] on_time_high_reg [NUM_REG_CH];
  logic [7:0] on_time_mid_reg [NUM_REG_CH];
  logic [7:0] ch1to4_on_time_lsbs_reg;
  logic [ON_W-1:0] on_time_value [NUM_CH];
  logic [3:0] low_flags;
  logic [5:0] step_acc_reg;
  logic [6:0] step_sum;
  logic step_tick;
  logic dim_meta_reg;
  logic dim_sync_reg;
  logic dim_prev_reg;
  logic [ON_W-1:0] pin_high_cnt_reg;
  logic [ON_W-1:0] pin_per_cnt_reg;
  logic [ON_W-1:0] pin_on_reg;
  logic [ON_W-1:0] pin_period_reg;

  // ----------------------------------------------------------------
  // serial register port
  // ----------------------------------------------------------------
  dim_i2c_target #(
    .TARGET_ADDR(TARGET_ADDR)
  ) u_target (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .wr_pulse_out(wr_pulse),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data)
  );

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  // only the low nibble stores; the flag nibble ignores writes
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_ctrl_reg <= MODE_RESET;
    end else if (wr_pulse && wr_addr == MODE_ADDR) begin
      mode_ctrl_reg <= wr_data[3:0];
    end
  end
  assign external_dim_select_out = mode_ctrl_reg[EXT_BIT];
  assign hybrid_dim_enable_out = mode_ctrl_reg[HYB_BIT];
  assign crossover_threshold_field_out = mode_ctrl_reg[THR_MSB:0];
  assign ch_low_level_flag_out = low_flags;

  // ----------------------------------------------------------------
  // shared low-bit register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ch1to4_on_time_lsbs_reg <= LSB_RESET;
    end else if (wr_pulse && wr_addr == LSB_ADDR) begin
      ch1to4_on_time_lsbs_reg <= wr_data;
    end
  end
  assign ch4_on_time_lsbs_out = ch1to4_on_time_lsbs_reg[7:6];

  // ----------------------------------------------------------------
  // 50 ns step tick: 4 ns per clock does not divide 50 ns, so an
  // accumulator alternates 12 and 13 cycle gaps, exact on average
  // ----------------------------------------------------------------
  assign step_sum = {1'b0, step_acc_reg} + {1'b0, CLK_NS};
  assign step_tick = (step_sum >= {1'b0, STEP_NS});
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      step_acc_reg <= 6'h00;
    end else begin
      step_acc_reg <= step_tick ? step_sum[5:0] - STEP_NS : step_sum[5:0];
    end
  end

  // ----------------------------------------------------------------
  // dimming pin: synchronise, then measure high time and period
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dim_meta_reg <= 1'b0;
      dim_sync_reg <= 1'b0;
      dim_prev_reg <= 1'b0;
    end else begin
      dim_meta_reg <= dim_pin_in;
      dim_sync_reg <= dim_meta_reg;
      dim_prev_reg <= dim_sync_reg;
    end
  end
  // counters saturate so a stuck pin cannot wrap into a false duty
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_high_cnt_reg <= '0;
      pin_per_cnt_reg <= '0;
      pin_on_reg <= '0;
      pin_period_reg <= '0;
    end else if (dim_sync_reg && !dim_prev_reg) begin
      pin_on_reg <= pin_high_cnt_reg;
      pin_period_reg <= pin_per_cnt_reg;
      pin_high_cnt_reg <= '0;
      pin_per_cnt_reg <= '0;
    end else if (step_tick) begin
      if (pin_per_cnt_reg != '1) begin
        pin_per_cnt_reg <= pin_per_cnt_reg + ON_W'(1);
      end
      if (dim_sync_reg && pin_high_cnt_reg != '1) begin
        pin_high_cnt_reg <= pin_high_cnt_reg + ON_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel on-time bytes and dimming engines
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      if (ch < NUM_REG_CH) begin : g_regs
        // high byte then middle byte, each at its own offset
        always_ff @(posedge clk_in or negedge reset_n_in) begin
          if (!reset_n_in) begin
            on_time_high_reg[ch] <= ON_BYTE_RESET;
            on_time_mid_reg[ch] <= ON_BYTE_RESET;
          end else if (wr_pulse) begin
            if (wr_addr == HIGH_ADDR[ch]) begin
              on_time_high_reg[ch] <= wr_data;
            end
            if (wr_addr == MID_ADDR[ch]) begin
              on_time_mid_reg[ch] <= wr_data;
            end
          end
        end
        // 17:10 high, 9:2 middle, 1:0 from the shared register
        assign on_time_value[ch] = {on_time_high_reg[ch], on_time_mid_reg[ch],
                                    ch1to4_on_time_lsbs_reg[2*ch+1 -: 2]};
        a_high_byte_maps: assert property (@(posedge clk_in) disable iff (!reset_n_in)
          (wr_pulse && wr_addr == HIGH_ADDR[ch]) |=>
            on_time_value[ch][ON_W-1:HIGH_LSB] == $past(wr_data))
          else $error("high byte did not land in bits 17:10");
        a_mid_byte_maps: assert property (@(posedge clk_in) disable iff (!reset_n_in)
          (wr_pulse && wr_addr == MID_ADDR[ch]) |=>
            on_time_value[ch][HIGH_LSB-1:MID_LSB] == $past(wr_data))
          else $error("middle byte did not land in bits 9:2");
      end else begin : g_ext
        // upper bits of channel 4 live in registers outside this bank
        assign on_time_value[ch] = {ch4_on_time_upper_in, ch1to4_on_time_lsbs_reg[7:6]};
      end
      dim_channel u_channel (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .step_tick_in(step_tick),
        .ext_select_in(mode_ctrl_reg[EXT_BIT]),
        .pin_level_in(dim_sync_reg),
        .hybrid_en_in(mode_ctrl_reg[HYB_BIT]),
        .threshold_in(mode_ctrl_reg[THR_MSB:0]),
        .on_time_in(on_time_value[ch]),
        .period_in(pwm_period_in),
        .pin_on_in(pin_on_reg),
        .pin_period_in(pin_period_reg),
        .pwm_out(ch_pwm_out[ch]),
        .low_dim_out(low_flags[ch])
      );
    end
  endgenerate
  assign ch1_on_time_value_out = on_time_value[0];
  assign ch2_on_time_value_out = on_time_value[1];
  assign ch3_on_time_value_out = on_time_value[2];

  // ----------------------------------------------------------------
  // read mux: unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr == MODE_ADDR) begin
      rd_data = {low_flags, mode_ctrl_reg};
    end
    if (rd_addr == LSB_ADDR) begin
      rd_data = ch1to4_on_time_lsbs_reg;
    end
    for (int i = 0; i < NUM_REG_CH; i++) begin
      if (rd_addr == HIGH_ADDR[i]) begin
        rd_data = on_time_high_reg[i];
      end
      if (rd_addr == MID_ADDR[i]) begin
        rd_data = on_time_mid_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_flags_read_only: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (rd_addr == MODE_ADDR) |-> rd_data[7:FLAG_LSB] == low_flags)
    else $error("mode read does not show channel flags");
  a_flags_ignore_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_pulse && wr_addr == MODE_ADDR && !mode_ctrl_reg[HYB_BIT] && !wr_data[HYB_BIT])
      |=> ##1 low_flags == 4'h0)
    else $error("flag bits followed a write");
  a_ext_pin_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode_ctrl_reg[EXT_BIT] |=> ch_pwm_out == {NUM_CH{$past(dim_sync_reg)}})
    else $error("pin dimming not followed");
  a_reg_mode_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!mode_ctrl_reg[EXT_BIT] && on_time_value[0] == '0) |=> !ch_pwm_out[0])
    else $error("zero on-time still drives channel 1");
  a_ext_reset_one: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !$past(reset_n_in) |-> mode_ctrl_reg == MODE_RESET)
    else $error("mode reset value wrong");
  a_hybrid_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_pulse && wr_addr == MODE_ADDR) |=> hybrid_dim_enable_out == $past(wr_data[HYB_BIT]))
    else $error("hybrid enable not written");
  a_thr_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_pulse && wr_addr == MODE_ADDR) |=>
      crossover_threshold_field_out == $past(wr_data[THR_MSB:0]))
    else $error("threshold field not written");
  // gap counter for the tick spacing checks; a wrong gap would skew
  // every on-time, and saturating keeps a stalled tick visible
  logic [3:0] tick_gap_reg;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_gap_reg <= 4'h0;
    end else if (step_tick) begin
      tick_gap_reg <= 4'h1;
    end else if (tick_gap_reg != 4'hf) begin
      tick_gap_reg <= tick_gap_reg + 4'h1;
    end
  end
  a_step_spacing: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    step_tick |-> (tick_gap_reg == 4'(STEP_NS / CLK_NS) ||
      tick_gap_reg == 4'(STEP_NS / CLK_NS) + 4'h1))
    else $error("50 ns step spacing wrong");
  a_step_no_stall: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    tick_gap_reg <= 4'(STEP_NS / CLK_NS) + 4'h1)
    else $error("50 ns step tick stalled");
  a_lsb_shared: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_pulse && wr_addr == LSB_ADDR) |=>
      (ch1_on_time_value_out[1:0] == $past(wr_data[1:0])) &&
      (ch2_on_time_value_out[1:0] == $past(wr_data[3:2])) &&
      (ch3_on_time_value_out[1:0] == $past(wr_data[5:4])) &&
      (ch4_on_time_lsbs_out == $past(wr_data[7:6])))
    else $error("shared low bits misplaced");
  c_ext_cleared: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(mode_ctrl_reg[EXT_BIT]));
  c_flag_set: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(low_flags[0]));
  c_on_time_write: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    wr_pulse && wr_addr == HIGH_ADDR[0]);
  c_pin_measured: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    dim_sync_reg && !dim_prev_reg && pin_per_cnt_reg > 18'h00002);
  c_pin_hybrid: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    mode_ctrl_reg[EXT_BIT] && mode_ctrl_reg[HYB_BIT] && low_flags == 4'hf);
endmodule // dimming_mode_and_on_time_regs

//--- hdl/dim_regs_pkg.sv
package dim_regs_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int NUM_REG_CH = 3;
  localparam logic [7:0] MODE_ADDR = 8'h03;
  localparam logic [7:0] HIGH_ADDR [NUM_REG_CH] = '{8'h04, 8'h06, 8'h08};
  localparam logic [7:0] MID_ADDR [NUM_REG_CH] = '{8'h05, 8'h07, 8'h09};
  localparam logic [7:0] LSB_ADDR = 8'h0c;
  // ----------------------------------------------------------------
  // mode field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_LSB = 4;
  localparam int EXT_BIT = 3;
  localparam int HYB_BIT = 2;
  localparam int THR_MSB = 1;
  localparam logic [3:0] MODE_RESET = 4'h8;
  localparam logic [7:0] ON_BYTE_RESET = 8'h7f;
  localparam logic [7:0] LSB_RESET = 8'hff;
  localparam int HIGH_LSB = 10;
  localparam int MID_LSB = 2;
  localparam int ON_W = 18;
  // ----------------------------------------------------------------
  // timing: 50 ns on-time step from a 4 ns clock
  // ----------------------------------------------------------------
  localparam logic [5:0] STEP_NS = 6'h32;
  localparam logic [5:0] CLK_NS = 6'h04;
endpackage

//--- hdl/dim_i2c_target.sv
`timescale 1ns/1ps
module dim_i2c_target #(
  parameter logic [6:0] TARGET_ADDR = 7'h28
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // register side
  output logic wr_pulse_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  output logic [7:0] rd_addr_out,
  input wire logic [7:0] rd_data_in
);
  typedef enum {S_IDLE, S_ADDR, S_ACK_ADDR, S_PTR, S_ACK_PTR, S_WDATA, S_ACK_WDATA,
                S_RDATA, S_ACK_RDATA} i2c_state_t;
  i2c_state_t state_reg;
  logic [2:0] scl_reg, sda_reg;
  logic [7:0] shift_reg, ptr_reg;
  logic [2:0] cnt_reg;
  logic full_reg, rw_reg, drive_reg, ack_ok_reg;
  logic rise, fall, start, stop;
  // two flops before use; bit 2 is the previous synced sample
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_reg <= 3'h7;
      sda_reg <= 3'h7;
    end else begin
      scl_reg <= {scl_reg[1:0], scl_in};
      sda_reg <= {sda_reg[1:0], sda_in};
    end
  end
  assign rise = scl_reg[1] & ~scl_reg[2];
  assign fall = ~scl_reg[1] & scl_reg[2];
  assign start = scl_reg[1] & scl_reg[2] & sda_reg[2] & ~sda_reg[1];
  assign stop = scl_reg[1] & scl_reg[2] & ~sda_reg[2] & sda_reg[1];
  assign sda_out = 1'b0;
  assign sda_oe_out = drive_reg;
  assign rd_addr_out = ptr_reg;
  // byte engine: sample on scl rise, change sda only on scl fall
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      cnt_reg <= 3'h0;
      full_reg <= 1'b0;
      rw_reg <= 1'b0;
      drive_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      wr_pulse_out <= 1'b0;
      wr_addr_out <= 8'h00;
      wr_data_out <= 8'h00;
    end else begin
      wr_pulse_out <= 1'b0;
      if (start || stop) begin
        state_reg <= start ? S_ADDR : S_IDLE;
        cnt_reg <= 3'h0;
        full_reg <= 1'b0;
        drive_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_ADDR, S_PTR, S_WDATA: begin
            if (rise) begin
              shift_reg <= {shift_reg[6:0], sda_reg[1]};
              cnt_reg <= cnt_reg + 3'h1;
              full_reg <= (cnt_reg == 3'h7);
            end else if (fall && full_reg) begin
              full_reg <= 1'b0;
              drive_reg <= 1'b1;
              if (state_reg == S_ADDR) begin
                rw_reg <= shift_reg[0];
                drive_reg <= (shift_reg[7:1] == TARGET_ADDR);
                state_reg <= (shift_reg[7:1] == TARGET_ADDR) ? S_ACK_ADDR : S_IDLE;
              end else if (state_reg == S_PTR) begin
                ptr_reg <= shift_reg;
                state_reg <= S_ACK_PTR;
              end else begin
                wr_pulse_out <= 1'b1;
                wr_addr_out <= ptr_reg;
                wr_data_out <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= S_ACK_WDATA;
              end
            end
          end
          S_ACK_ADDR, S_ACK_PTR, S_ACK_WDATA: begin
            if (fall) begin
              cnt_reg <= 3'h0;
              if (state_reg == S_ACK_ADDR && rw_reg) begin
                shift_reg <= rd_data_in;
                drive_reg <= ~rd_data_in[7];
                state_reg <= S_RDATA;
              end else begin
                drive_reg <= 1'b0;
                state_reg <= (state_reg == S_ACK_ADDR) ? S_PTR : S_WDATA;
              end
            end
          end
          S_RDATA: begin
            if (fall) begin
              cnt_reg <= cnt_reg + 3'h1;
              shift_reg <= {shift_reg[6:0], 1'b0};
              drive_reg <= (cnt_reg == 3'h7) ? 1'b0 : ~shift_reg[6];
              if (cnt_reg == 3'h7) begin
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= S_ACK_RDATA;
              end
            end
          end
          S_ACK_RDATA: begin
            if (rise) begin
              ack_ok_reg <= ~sda_reg[1];
            end else if (fall) begin
              cnt_reg <= 3'h0;
              shift_reg <= rd_data_in;
              drive_reg <= ack_ok_reg & ~rd_data_in[7];
              state_reg <= ack_ok_reg ? S_RDATA : S_IDLE;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule // dim_i2c_target

//--- hdl/dim_channel.sv
`timescale 1ns/1ps
module dim_channel
  import dim_regs_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic step_tick_in,
  input wire logic ext_select_in,
  input wire logic pin_level_in,
  input wire logic hybrid_en_in,
  input wire logic [1:0] threshold_in,
  // duty sources, in 50 ns steps
  input wire logic [ON_W-1:0] on_time_in,
  input wire logic [ON_W-1:0] period_in,
  input wire logic [ON_W-1:0] pin_on_in,
  input wire logic [ON_W-1:0] pin_period_in,
  // results
  output logic pwm_out,
  output logic low_dim_out
);
  logic [ON_W-1:0] count_reg;
  logic [ON_W+3:0] scaled_on, cmd_per;
  logic [ON_W-1:0] cmd_on;
  // step counter across the register-mode period
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_reg <= '0;
    end else if (step_tick_in) begin
      count_reg <= (count_reg + ON_W'(1) >= period_in) ? '0 : count_reg + ON_W'(1);
    end
  end
  // pin mode passes the pin, register mode compares on-time steps
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= ext_select_in ? pin_level_in : (count_reg < on_time_in);
    end
  end
  // duty below threshold: on * 2^k < period, k = 4,3,2,1
  always_comb begin
    cmd_on = ext_select_in ? pin_on_in : on_time_in;
    cmd_per = {4'h0, ext_select_in ? pin_period_in : period_in};
    case (threshold_in)
      2'h0: scaled_on = {cmd_on, 4'h0};
      2'h1: scaled_on = {1'b0, cmd_on, 3'h0};
      2'h2: scaled_on = {2'h0, cmd_on, 2'h0};
      default: scaled_on = {3'h0, cmd_on, 1'b0};
    endcase
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_dim_out <= 1'b0;
    end else begin
      low_dim_out <= hybrid_en_in && (scaled_on < cmd_per);
    end
  end
  a_flag_needs_hybrid: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !hybrid_en_in |=> !low_dim_out) else $error("low-dim flag set without hybrid");
  a_flag_on_low_duty: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (hybrid_en_in && scaled_on < cmd_per) |=> low_dim_out) else $error("low-dim flag missed");
endmodule // dim_channel

//--- tb/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
  // clock
  input wire logic clk_in,
  // bus pins, sda is the resolved open-drain line
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  int nacks = 0;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // ------------------------------------------------------------
  // bit steps: phases of 8 clocks, data moved 4 clocks after scl falls
  // ------------------------------------------------------------
  task automatic w(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic pulse(output logic s);
    w(4);
    scl_out = 1'b1;
    w(4);
    s = sda_in;
    w(4);
    scl_out = 1'b0;
    w(4);
  endtask
  // start also serves as repeated start
  task automatic start();
    sda_low_out = 1'b0;
    w(4);
    scl_out = 1'b1;
    w(8);
    sda_low_out = 1'b1;
    w(8);
    scl_out = 1'b0;
    w(4);
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    w(4);
    scl_out = 1'b1;
    w(8);
    sda_low_out = 1'b0;
    w(8);
  endtask
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = ~b[i];
      pulse(s);
    end
    sda_low_out = 1'b0;
    pulse(s);
    if (s) nacks++;
  endtask
  // ------------------------------------------------------------
  // register transfers, pointer then data bytes
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d [$]);
    start();
    send(8'h50);
    send(a);
    foreach (d[i]) send(d[i]);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q [$]);
    logic [7:0] b;
    logic s;
    q = {};
    start();
    send(8'h50);
    send(a);
    start();
    send(8'h51);
    for (int k = 0; k < n; k++) begin
      sda_low_out = 1'b0;
      for (int i = 7; i >= 0; i--) pulse(b[i]);
      // acknowledge all but the last byte so the target stops driving
      sda_low_out = (k != n - 1);
      pulse(s);
      q.push_back(b);
    end
    stop();
  endtask
endmodule // i2c_host_model

//--- tb/dimming_mode_and_on_time_regs_tb_top.sv
`timescale 1ns/1ps
module dimming_mode_and_on_time_regs_tb_top
  import dim_regs_pkg::*;
;
  logic clk_in, reset_n_in, scl, host_low, sda_oe, dim_pin;
  logic [17:0] period, v1, v2, v3;
  logic [15:0] ch4_upper;
  logic ext, hyb;
  logic [1:0] thr, l4;
  logic [3:0] pwm, flag;
  wire logic sda_line = ~(host_low | sda_oe);
  int n_fail = 0;
  int n_tests = 0;
  i2c_host_model host (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl),
    .sda_low_out(host_low));
  dimming_mode_and_on_time_regs uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe),
    .dim_pin_in(dim_pin), .pwm_period_in(period), .ch4_on_time_upper_in(ch4_upper),
    .external_dim_select_out(ext), .hybrid_dim_enable_out(hyb),
    .crossover_threshold_field_out(thr), .ch1_on_time_value_out(v1),
    .ch2_on_time_value_out(v2), .ch3_on_time_value_out(v3), .ch4_on_time_lsbs_out(l4),
    .ch_pwm_out(pwm), .ch_low_level_flag_out(flag));
  // ------------------------------------------------------------
  // compare and verdict
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // watchdog: the sequence needs roughly 20k clocks, allow twice that
  initial begin
    #160000;
    n_fail++;
    results();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [7:0] q [$];
    logic [7:0] e [$];
    int hi;
    reset_n_in = 1'b0;
    dim_pin = 1'b0;
    period = 18'h00100;
    ch4_upper = 16'h0000;
    repeat (8) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    check(ext, 1'b1);
    check({hyb, thr}, 3'h0);
    check(v1, 18'h1fdff);
    check(l4, 2'h3);
    host.rd(MODE_ADDR, 1, q);
    check(q[0], 8'h08);
    // writes to the status bits are dropped while hybrid stays off
    host.wr(MODE_ADDR, '{8'hf8});
    host.rd(MODE_ADDR, 1, q);
    check(q[0], 8'h08);
    // pin mode: drive follows the external pin
    dim_pin = 1'b1;
    repeat (6) @(negedge clk_in);
    check(pwm, 4'hf);
    dim_pin = 1'b0;
    repeat (6) @(negedge clk_in);
    check(pwm, 4'h0);
    // status bits ignore writes; only channel 4 (on-time 3) is below 50 percent
    host.wr(MODE_ADDR, '{8'hf7});
    host.rd(MODE_ADDR, 1, q);
    check(q[0], 8'h87);
    // burst across the map, 0x0a and 0x0b are not in this bank
    e = '{8'h00, 8'h08, 8'h12, 8'h34, 8'h03, 8'hff, 8'h00, 8'h00, 8'hd8};
    host.wr(8'h04, '{8'h00, 8'h08, 8'h12, 8'h34, 8'h03, 8'hff, 8'h55, 8'h55, 8'hd8});
    host.rd(8'h04, 9, q);
    foreach (e[i]) check(q[i], e[i]);
    check(v1, 18'h00020);
    check(v2, 18'h048d2);
    check(v3, 18'h00ffd);
    // ch1 at 32 of 256 steps: k of 3 hits the equality boundary, no flag
    for (int t = 0; t < 4; t++) begin
      host.wr(MODE_ADDR, '{8'h04 | t[7:0]});
      repeat (4) @(negedge clk_in);
      check(thr, t[1:0]);
      check(flag, {3'b100, t >= 2});
      host.rd(MODE_ADDR, 1, q);
      check(q[0], {3'b100, t >= 2, 4'h4 | t[3:0]});
    end
    // pin mode with hybrid: 25 percent pin duty is below 50 but not 6.25
    host.wr(MODE_ADDR, '{8'h0f});
    repeat (3) begin
      dim_pin = 1'b1;
      repeat (100) @(negedge clk_in);
      dim_pin = 1'b0;
      repeat (300) @(negedge clk_in);
    end
    check(flag, 4'hf);
    host.rd(MODE_ADDR, 1, q);
    check(q[0], 8'hff);
    host.wr(MODE_ADDR, '{8'h0c});
    repeat (4) @(negedge clk_in);
    check(flag, 4'h0);
    host.wr(MODE_ADDR, '{8'h00});
    repeat (4) @(negedge clk_in);
    check(flag, 4'h0);
    // register mode ignores the pin: one period is 3200 clocks, 400 high
    dim_pin = 1'b1;
    hi = 0;
    repeat (3200) begin
      @(negedge clk_in);
      if (pwm[0] === 1'b1) hi++;
    end
    check(hi >= 385 && hi <= 415, 1'b1);
    // zero on-time keeps channel 1 dark in register mode
    host.wr(8'h05, '{8'h00});
    check(v1, 18'h00000);
    hi = 0;
    repeat (400) begin
      @(negedge clk_in);
      if (pwm[0] !== 1'b0) hi++;
    end
    check(hi, 0);
    check(host.nacks, 0);
    results();
  end
endmodule // dimming_mode_and_on_time_regs_tb_top
